// *** core/amws_pkg.sv ***
package amws_pkg;

    // register bus
    localparam int         REG_AW      = 4;
    localparam logic [3:0] REG_CFG     = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;

    // bus, counter and turnaround widths
    localparam int ADDR_W  = 22;
    localparam int BANK_W  = 2;
    localparam int EDATA_W = 16;
    localparam int WORD_W  = 32;
    localparam int BE_W    = 4;
    localparam int EBE_W   = 2;
    localparam int CNT_W   = 6;
    localparam int TA_W    = 2;

    localparam logic [CNT_W-1:0]  CNT_ZERO  = 6'h00;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 6'h01;
    localparam logic [TA_W-1:0]   TA_ZERO   = 2'h0;
    localparam logic [TA_W-1:0]   TA_ONE    = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 22'h000001;

    // async configuration register layout, msb first
    typedef struct packed {
        logic [1:0] turnaround_cycles;
        logic [3:0] r_setup;
        logic [5:0] r_strobe;
        logic [2:0] r_hold;
        logic [3:0] w_setup;
        logic [5:0] w_strobe;
        logic [2:0] w_hold;
    } amws_cfg_t;

    localparam int CFG_W = $bits(amws_cfg_t);

    localparam amws_cfg_t CFG_RESET = '{
        turnaround_cycles: 2'h1,
        r_setup:           4'h1,
        r_strobe:          6'h04,
        r_hold:            3'h1,
        w_setup:           4'h1,
        w_strobe:          6'h04,
        w_hold:            3'h1
    };

    // request from the internal arbiter side
    typedef struct packed {
        logic               valid;
        logic               write;
        logic               two_beats;
        logic [BANK_W-1:0]  bank;
        logic [ADDR_W-1:0]  addr;
        logic [WORD_W-1:0]  wdata;
        logic [BE_W-1:0]    byte_en;
    } amws_req_t;

    // external memory pins
    typedef struct packed {
        logic               chip_select_n;
        logic               output_enable_n;
        logic               write_enable_n;
        logic               read_write_n;
        logic [EBE_W-1:0]   byte_write_strobe_n;
        logic [ADDR_W-1:0]  ext_addr;
        logic [BANK_W-1:0]  ext_bank_addr;
        logic [EDATA_W-1:0] data_out;
        logic               data_oe;
    } amws_pins_t;

    localparam amws_pins_t PINS_IDLE = '{
        chip_select_n:       1'b1,
        output_enable_n:     1'b1,
        write_enable_n:      1'b1,
        read_write_n:        1'b1,
        byte_write_strobe_n: 2'h3,
        ext_addr:            22'h000000,
        ext_bank_addr:       2'h0,
        data_out:            16'h0000,
        data_oe:             1'b0
    };

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_TURN   = 3'h1,
        ST_SETUP  = 3'h3,
        ST_STROBE = 3'h2,
        ST_HOLD   = 3'h6
    } amws_state_e_t;

endpackage

// *** core/amws_seq.sv ***
`timescale 1ns/10ps
// Functional notes
// R01 - read: pull output enable low as the strobe phase begins
// R02 - read: release output enable on the edge ending the strobe phase
// R03 - capture data bus at strobe end; memory has data valid by then
// R04 - wait input held high stretches the strobe phase
// R05 - address and bank address may stop being valid after hold ends
// R06 - chip select released after hold only when no access remains
// R07 - narrow multi-access: hold goes straight to setup, no turnaround
// R08 - chained accesses reuse counts latched for the first access
// R09 - after last access return to idle unless a top request waits
// R10 - waiting top request after completion enters its turnaround directly
// R11 - start a write only when it is the top priority task
// R12 - write needing several accesses issues them until all is moved
// R13 - output enable stays high for the whole of every write
// R14 - write waits programmed turnaround cycles before its setup
// R15 - write right after a write gets no turnaround cycles
// R16 - write right after a read with turnaround zero gets one cycle
// R17 - after turnaround, recheck that the access is still top priority
// R18 - access no longer top after turnaround is dropped, no setup
// R19 - read right after a read gets no turnaround cycles
// R20 - write setup loads write counts, drives address, data, rw low
// R21 - read keeps write enable, byte strobes and rw indicator high
// R22 - setup, strobe and hold each counted from their latched count
module amws_seq
    import amws_pkg::*;
(
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    // register port
    input  wire logic [REG_AW-1:0]  i_reg_addr,
    input  wire logic [WORD_W-1:0]  i_reg_wdata,
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    output logic      [WORD_W-1:0]  o_reg_rdata,
    // request side
    input  wire amws_req_t          i_req,
    input  wire logic               i_req_top,
    output logic                    o_req_start,
    output logic                    o_req_done,
    output logic                    o_req_abort,
    output logic      [WORD_W-1:0]  o_rsp_rdata,
    // external memory
    output amws_pins_t              o_pins,
    input  wire logic [EDATA_W-1:0] i_ext_data_bus,
    input  wire logic               i_ext_wait_in
);

    typedef struct packed {
        amws_state_e_t      st;
        amws_cfg_t          cfg;
        logic [CNT_W-1:0]   cnt;
        logic [3:0]         l_setup;
        logic [5:0]         l_strobe;
        logic [2:0]         l_hold;
        logic               is_write;
        logic               two_beats;
        logic               beat;
        logic [WORD_W-1:0]  wdata;
        logic [BE_W-1:0]    byte_en;
        logic               prev_valid;
        logic               prev_write;
        amws_pins_t         pins;
        logic [WORD_W-1:0]  rdata;
        logic               start;
        logic               done;
        logic               abort;
        logic [1:0]         wait_sync;
        logic [EDATA_W-1:0] din_s0;
        logic [EDATA_W-1:0] din_s1;
        logic [WORD_W-1:0]  reg_rdata;
    } amws_regs_t;

    amws_regs_t r;
    amws_regs_t next_r;

    localparam amws_regs_t REGS_RESET = '{
        st:         ST_IDLE,
        cfg:        CFG_RESET,
        pins:       PINS_IDLE,
        default:    '0
    };

    // turnaround length for the request about to start
    function automatic logic [TA_W-1:0] ta_len(
        input logic            direct,
        input logic            prev_write,
        input logic            is_write,
        input logic [TA_W-1:0] ta
    );
        logic [TA_W-1:0] len;
        len = ta;
        if (direct && (prev_write == is_write)) begin
            // R15 R19 - same direction back to back
            len = TA_ZERO;
        end else if (direct && (ta == TA_ZERO)) begin
            // R16 - direction change needs a cycle
            len = TA_ONE;
        end
        return len;
    endfunction

    // latch request and counts, drive setup pins
    function automatic amws_regs_t start_setup(
        input amws_regs_t s,
        input amws_req_t  q
    );
        amws_regs_t t;
        t = s;
        t.st        = ST_SETUP;
        t.is_write  = q.write;
        t.two_beats = q.two_beats;
        t.beat      = 1'b0;
        t.wdata     = q.wdata;
        t.byte_en   = q.byte_en;
        t.start     = 1'b1;
        // R20 - write counts loaded for a write
        t.l_setup  = q.write ? s.cfg.w_setup  : s.cfg.r_setup;
        t.l_strobe = q.write ? s.cfg.w_strobe : s.cfg.r_strobe;
        t.l_hold   = q.write ? s.cfg.w_hold   : s.cfg.r_hold;
        t.cnt      = CNT_W'(t.l_setup);
        t.pins.chip_select_n       = 1'b0;
        t.pins.output_enable_n     = 1'b1;
        t.pins.write_enable_n      = 1'b1;
        // R20 R21 - rw low only for writes
        t.pins.read_write_n        = ~q.write;
        t.pins.byte_write_strobe_n = {EBE_W{1'b1}};
        t.pins.ext_addr            = q.addr;
        t.pins.ext_bank_addr       = q.bank;
        t.pins.data_out            = q.wdata[EDATA_W-1:0];
        t.pins.data_oe             = q.write;
        return t;
    endfunction

    // enter turnaround, or setup at once when no cycles are due
    function automatic amws_regs_t begin_access(
        input amws_regs_t s,
        input amws_req_t  q,
        input logic       direct
    );
        amws_regs_t      t;
        logic [TA_W-1:0] len;
        t   = s;
        // R14 - programmed turnaround first
        len = ta_len(direct, s.prev_write, q.write,
                     s.cfg.turnaround_cycles);
        if (len == TA_ZERO) begin
            t = start_setup(s, q);
        end else begin
            t.st  = ST_TURN;
            t.cnt = CNT_W'(len - TA_ONE);
        end
        return t;
    endfunction

    always_comb begin
        next_r           = r;
        next_r.start     = 1'b0;
        next_r.done      = 1'b0;
        next_r.abort     = 1'b0;
        // pins pass two stages before use
        next_r.wait_sync = {r.wait_sync[0], i_ext_wait_in};
        next_r.din_s0    = i_ext_data_bus;
        next_r.din_s1    = r.din_s0;

        next_r.reg_rdata = '0;
        if (i_reg_rd) begin
            case (i_reg_addr)
                REG_CFG: begin
                    next_r.reg_rdata = WORD_W'(r.cfg);
                end
                REG_STATUS: begin
                    next_r.reg_rdata = WORD_W'({r.st, r.is_write, r.beat,
                                                r.prev_valid,
                                                r.prev_write,
                                                r.wait_sync[1]});
                end
                default: begin
                    next_r.reg_rdata = '0;
                end
            endcase
        end
        // new counts take effect on the next request only
        if (i_reg_wr && (i_reg_addr == REG_CFG)) begin
            next_r.cfg = amws_cfg_t'(i_reg_wdata[CFG_W-1:0]);
        end

        case (r.st)
            ST_IDLE: begin
                // R11 - only a top priority request starts
                if (i_req.valid && i_req_top) begin
                    next_r = begin_access(next_r, i_req, 1'b0);
                end
            end
            ST_TURN: begin
                if (r.cnt != CNT_ZERO) begin
                    next_r.cnt = r.cnt - CNT_ONE;
                // R17 - priority checked again
                end else if (i_req.valid && i_req_top) begin
                    next_r = start_setup(next_r, i_req);
                end else begin
                    // R18 - lost priority, drop the access
                    next_r.st         = ST_IDLE;
                    next_r.abort      = 1'b1;
                    next_r.prev_valid = 1'b0;
                end
            end
            ST_SETUP: begin
                // R22 - setup counted down
                if (r.cnt != CNT_ZERO) begin
                    next_r.cnt = r.cnt - CNT_ONE;
                end else begin
                    next_r.st  = ST_STROBE;
                    next_r.cnt = CNT_W'(r.l_strobe);
                    // R01 R13 - oe low on reads only
                    next_r.pins.output_enable_n = r.is_write;
                    next_r.pins.write_enable_n  = ~r.is_write;
                    // R21 - strobes stay high on reads
                    next_r.pins.byte_write_strobe_n = r.is_write ?
                        (r.beat ? ~r.byte_en[BE_W-1:EBE_W]
                                : ~r.byte_en[EBE_W-1:0])
                        : {EBE_W{1'b1}};
                end
            end
            ST_STROBE: begin
                if (r.cnt != CNT_ZERO) begin
                    next_r.cnt = r.cnt - CNT_ONE;
                // R04 - wait pin stretches the last strobe cycle
                end else if (!r.wait_sync[1]) begin
                    next_r.st  = ST_HOLD;
                    next_r.cnt = CNT_W'(r.l_hold);
                    // R02 - oe back high at strobe end
                    next_r.pins.output_enable_n     = 1'b1;
                    next_r.pins.write_enable_n      = 1'b1;
                    next_r.pins.byte_write_strobe_n = {EBE_W{1'b1}};
                    // R03 - sample the bus, halves by beat
                    if (!r.is_write) begin
                        if (r.beat) begin
                            next_r.rdata[WORD_W-1:EDATA_W] = r.din_s1;
                        end else begin
                            next_r.rdata[EDATA_W-1:0] = r.din_s1;
                        end
                    end
                end
            end
            ST_HOLD: begin
                if (r.cnt != CNT_ZERO) begin
                    next_r.cnt = r.cnt - CNT_ONE;
                end else if (r.two_beats && !r.beat) begin
                    // R07 R08 R12 - next access, counts kept
                    next_r.st            = ST_SETUP;
                    next_r.cnt           = CNT_W'(r.l_setup);
                    next_r.beat          = 1'b1;
                    next_r.pins.ext_addr = r.pins.ext_addr + ADDR_STEP;
                    next_r.pins.data_out = r.wdata[WORD_W-1:EDATA_W];
                end else begin
                    // R06 - select released, request finished
                    next_r.pins.chip_select_n = 1'b1;
                    next_r.pins.read_write_n  = 1'b1;
                    next_r.pins.data_oe       = 1'b0;
                    next_r.done               = 1'b1;
                    next_r.prev_valid         = 1'b1;
                    next_r.prev_write         = r.is_write;
                    // R05 - address left as is, no longer valid
                    if (i_req.valid && i_req_top) begin
                        // R10 - straight into the next turnaround
                        next_r = begin_access(next_r, i_req, 1'b1);
                    end else begin
                        // R09 - back to idle
                        next_r.st         = ST_IDLE;
                        next_r.prev_valid = 1'b0;
                    end
                end
            end
            default: begin
                next_r.st   = ST_IDLE;
                next_r.pins = PINS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    // all outputs come straight from the state register
    assign o_reg_rdata = r.reg_rdata;
    assign o_req_start = r.start;
    assign o_req_done  = r.done;
    assign o_req_abort = r.abort;
    assign o_rsp_rdata = r.rdata;
    assign o_pins      = r.pins;

endmodule

// *** dv/amws_mem_model.sv ***
`timescale 1ns/10ps
module amws_mem_model
    import amws_pkg::*;
(
    // clock and mode
    input  wire logic               i_clk,
    input  wire logic               i_slow,
    // pins from the sequencer
    input  wire amws_pins_t         i_pins,
    // answer to the sequencer
    output logic      [EDATA_W-1:0] o_data,
    output logic                    o_wait
);
    logic [EDATA_W-1:0] mem [16];
    logic [3:0]         cnt  = 4'h0;
    logic               act;
    initial o_data = 16'h5A5A;
    // slow part raises wait as soon as it is selected
    // the sequencer sees wait two flops late, so it must lead the strobe
    assign o_wait = i_slow && !i_pins.chip_select_n && cnt < 4'h5;
    assign act = !i_pins.chip_select_n
                 && !(i_pins.output_enable_n && i_pins.write_enable_n);
    always @(posedge i_clk) begin
        cnt <= (act && cnt != 4'hF) ? cnt + 4'h1 : (act ? cnt : 4'h0);
        // data only once ready, else garbage
        if (act && !i_pins.output_enable_n && !(i_slow && cnt < 4'h2))
            o_data <= mem[i_pins.ext_addr[3:0]];
        else
            o_data <= ~o_data;
        for (int b = 0; b < EBE_W; b++)
            if (act && !i_pins.byte_write_strobe_n[b])
                mem[i_pins.ext_addr[3:0]][8*b+:8] <= i_pins.data_out[8*b+:8];
    end
endmodule

// *** dv/amws_seq_chk.sv ***
`timescale 1ns/10ps
module amws_seq_chk
    import amws_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // request side
    input  wire logic       i_req_top,
    input  wire logic       o_req_start,
    input  wire logic       o_req_done,
    input  wire logic       o_req_abort,
    // memory side
    input  wire amws_pins_t o_pins,
    input  wire logic       i_ext_wait_in
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_rd_end;
        $rose(o_pins.output_enable_n);
    endsequence
    sequence s_wait_held;
        i_ext_wait_in [*3] ##0 !o_pins.output_enable_n;
    endsequence
    AST_OE_AFTER_SETUP: assert property (
        $fell(o_pins.output_enable_n) |-> !o_pins.chip_select_n
        && !$past(o_pins.chip_select_n)) else $error("oe fell without setup");
    AST_OE_END_IN_HOLD: assert property (
        s_rd_end |-> !o_pins.chip_select_n && o_pins.read_write_n)
        else $error("oe rose outside a read");
    AST_WAIT_STRETCH: assert property (
        s_wait_held |=> !o_pins.output_enable_n)
        else $error("strobe ended while wait held");
    AST_CS_ONLY_AT_DONE: assert property (
        $rose(o_pins.chip_select_n) |-> o_req_done)
        else $error("select released mid request");
    AST_START_ON_TOP: assert property (
        o_req_start |-> $past(i_req_top)) else $error("start without priority");
    AST_ABORT_QUIET: assert property (
        o_req_abort |-> o_pins.chip_select_n ##1
        (o_pins.chip_select_n && !o_req_start)) else $error("abort moved pins");
    AST_WR_OE_HIGH: assert property (
        !o_pins.read_write_n |-> o_pins.output_enable_n)
        else $error("oe low during write");
    AST_RD_WR_HIGH: assert property (
        !o_pins.output_enable_n |-> o_pins.write_enable_n
        && o_pins.read_write_n && (&o_pins.byte_write_strobe_n))
        else $error("write lines low during read");
    AST_WR_SETUP_FIRST: assert property (
        $fell(o_pins.write_enable_n) |-> !o_pins.read_write_n
        && o_pins.data_oe && !$past(o_pins.read_write_n))
        else $error("write strobe without setup");
endmodule
bind amws_seq amws_seq_chk amws_seq_chk_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req_top(i_req_top),
    .o_req_start(o_req_start), .o_req_done(o_req_done),
    .o_req_abort(o_req_abort), .o_pins(o_pins), .i_ext_wait_in(i_ext_wait_in)
);

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench
    import amws_pkg::*;
;
    logic               i_clk       = 1'b0;
    logic               i_sys_rst   = 1'b1;
    logic [REG_AW-1:0]  i_reg_addr  = 4'h0;
    logic [WORD_W-1:0]  i_reg_wdata = 32'h0;
    logic               i_reg_wr    = 1'b0;
    logic               i_reg_rd    = 1'b0;
    amws_req_t          i_req       = '0;
    logic               i_req_top   = 1'b0;
    logic               slow        = 1'b0;
    logic [WORD_W-1:0]  o_reg_rdata;
    logic [WORD_W-1:0]  o_rsp_rdata;
    logic               o_req_start;
    logic               o_req_done;
    logic               o_req_abort;
    amws_pins_t         o_pins;
    logic [EDATA_W-1:0] i_ext_data_bus;
    logic               i_ext_wait_in;
    logic [WORD_W-1:0]  rsp [32];
    amws_req_t          rq [$];
    int n_errors = 0, checks = 0, cyc = 0, n_start = 0, n_done = 0;
    int st [32], dn [32];

    always #2 i_clk = ~i_clk;

    amws_seq amws_seq_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_req(i_req), .i_req_top(i_req_top),
        .o_req_start(o_req_start), .o_req_done(o_req_done),
        .o_req_abort(o_req_abort), .o_rsp_rdata(o_rsp_rdata),
        .o_pins(o_pins), .i_ext_data_bus(i_ext_data_bus),
        .i_ext_wait_in(i_ext_wait_in)
    );
    amws_mem_model amws_mem_model_inst (
        .i_clk(i_clk), .i_slow(slow), .i_pins(o_pins),
        .o_data(i_ext_data_bus), .o_wait(i_ext_wait_in)
    );

    // timestamps kept apart from the tasks so same-edge events are not lost
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_req_start === 1'b1) begin
            st[n_start] <= cyc;
            n_start <= n_start + 1;
        end
        if (o_req_done === 1'b1) begin
            dn[n_done] <= cyc;
            rsp[n_done] <= o_rsp_rdata;
            n_done <= n_done + 1;
        end
    end

    task automatic chk(input logic [WORD_W-1:0] seen,
                       input logic [WORD_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [REG_AW-1:0] a, input logic [WORD_W-1:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [REG_AW-1:0] a, output logic [WORD_W-1:0] v);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(posedge i_clk);
        v = o_reg_rdata;
    endtask
    task automatic wt(input int sel);
        int n;
        logic s;
        n = 0;
        do begin
            @(posedge i_clk);
            s = sel == 0 ? o_req_start : (sel == 1 ? o_req_done : o_req_abort);
            n++;
        end while (s !== 1'b1 && n < 400);
        chk(32'(n >= 400), 32'h0);
    endtask
    // next request is offered as soon as the previous one starts
    task automatic chain();
        i_req_top <= 1'b1;
        foreach (rq[i]) begin
            i_req <= rq[i];
            wt(0);
        end
        i_req <= '0;
        wt(1);
        @(posedge i_clk);
    endtask
    function automatic amws_req_t mk(logic w, logic two, logic [ADDR_W-1:0] a,
                                     logic [WORD_W-1:0] d);
        mk = '{1'b1, w, two, 2'h1, a, d, 4'hF};
    endfunction
    function automatic logic [WORD_W-1:0] cf(logic [1:0] ta, logic [3:0] s,
                                             logic [5:0] t, logic [2:0] h);
        amws_cfg_t c;
        c = '{ta, s, t, h, s, t, h};
        return 32'(c);
    endfunction
    function automatic logic [WORD_W-1:0] g(int k);
        return 32'(st[k] - dn[k-1]);
    endfunction
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        give_verdict();
    end

    initial begin
        logic [WORD_W-1:0] v;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(REG_CFG, v);
        chk(v, 32'(CFG_RESET));
        rd(REG_STATUS, v);
        chk(v, 32'h0);
        wr(4'hC, 32'hFFFFFFFF);
        rd(4'hC, v);
        chk(v, 32'h0);
        wr(REG_CFG, cf(2'h0, 4'h0, 6'h03, 3'h0));
        rd(REG_CFG, v);
        chk(v, cf(2'h0, 4'h0, 6'h03, 3'h0));
        // access length 6: wide write, reads, narrow writes chained
        rq = {mk(1, 1, 22'h4, 32'hA5C31E7F), mk(0, 1, 22'h4, 32'h0),
              mk(0, 0, 22'h4, 32'h0), mk(1, 0, 22'h8, 32'h7E81),
              mk(1, 0, 22'h9, 32'h18E7)};
        chain();
        chk(32'(dn[0] - st[0]), 32'hC);
        chk(32'(dn[1] - st[1]), 32'hC);
        chk(rsp[1], 32'hA5C31E7F);
        chk(g(1), 32'h1);
        chk(g(2), 32'h0);
        chk(g(3), 32'h1);
        chk(g(4), 32'h0);
        chk(32'(o_pins.chip_select_n), 32'h1);
        wr(REG_CFG, cf(2'h2, 4'h0, 6'h03, 3'h0));
        rq = {mk(0, 0, 22'h8, 32'h0), mk(1, 0, 22'hA, 32'h3C3C)};
        chain();
        chk(g(6), 32'h2);
        // counts must stay latched while cfg changes mid request
        i_req <= mk(0, 1, 22'h4, 32'h0);
        wt(0);
        chk(32'({o_pins.ext_bank_addr, o_pins.ext_addr}), 32'h00400004);
        i_req <= '0;
        wr(REG_CFG, cf(2'h0, 4'h0, 6'h01, 3'h0));
        wt(1);
        @(posedge i_clk);
        chk(32'(dn[7] - st[7]), 32'hC);
        chk(rsp[7], 32'hA5C31E7F);
        slow <= 1'b1;
        rq = {mk(0, 1, 22'h4, 32'h0)};
        chain();
        chk(32'(dn[8] - st[8] > 8), 32'h1);
        chk(rsp[8], 32'hA5C31E7F);
        slow <= 1'b0;
        wr(REG_CFG, cf(2'h2, 4'h0, 6'h01, 3'h0));
        i_req_top <= 1'b0;
        i_req <= mk(1, 0, 22'h2, 32'h1);
        repeat (8) @(posedge i_clk);
        chk(32'(n_start), 32'h9);
        i_req_top <= 1'b1;
        @(posedge i_clk);
        i_req_top <= 1'b0;
        wt(2);
        i_req <= '0;
        repeat (3) @(posedge i_clk);
        chk(32'(n_start), 32'h9);
        give_verdict();
    end
endmodule
